//--- logic/ums_top.v
// modem signals, master reset and interrupt output with apb registers
`timescale 1ns/10ps
`include "ums_regs.vh"

module ums_top (
    input  wire        clock,
    input  wire        rst_b,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // modem side
    input  wire        masterResetIn,
    input  wire        clearSend_b,
    input  wire        setReady_b,
    input  wire        ringIndicate_b,
    input  wire        carrierDetect_b,
    output reg         terminalReady_b,
    output reg         requestSend_b,
    output reg         auxOutputFirst_b,
    output reg         auxOutputSecond_b,
    // serial line and framing engine
    input  wire        serialLineIn,
    input  wire        txSerialIn,
    output reg         rxSerialOut,
    output reg         serialEnable,
    input  wire        rxDataSet,
    input  wire        rxDataTaken,
    input  wire [3:0]  rxErrSet,
    input  wire        txHoldLoad,
    input  wire        txHoldFreed,
    input  wire        txShiftIdle,
    // host
    output reg         interruptRequestOut
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [7:0]  ier_r;
    reg  [7:0]  lcr_r;
    reg  [7:0]  mcr_r;
    reg  [7:0]  lsr_r;
    reg  [7:0]  lsr_nxt;
    reg  [7:0]  scr_r;
    reg         threPend_r;
    reg  [31:0] rdMux;
    reg         mapped;

    wire [3:0]  msrActive;
    wire [3:0]  msrDelta;
    wire [7:0]  msrValue;
    wire        irqAny;
    wire [7:0]  iid;
    wire [5:0]  wordIdx;
    wire        mr;

    // ----------------------------------------------------------------
    // register index decode
    // ----------------------------------------------------------------
    // one compare shared by reads, writes and read side effects, so the
    // three paths cannot disagree on which register is addressed
    function hitIdx;
        input [5:0] idx;
        input [3:0] code;
        begin
            hitIdx = (idx == {2'b00, code});
        end
    endfunction

    wire hitIer;
    wire hitIir;
    wire hitLcr;
    wire hitMcr;
    wire hitLsr;
    wire hitMsr;
    wire hitScr;
    wire hitSer;

    // index 0 (data buffers) belongs to the framing engine, so it
    // answers with an error here
    assign hitIer = hitIdx(wordIdx, `UMS_IDX_IER);
    assign hitIir = hitIdx(wordIdx, `UMS_IDX_IIR);
    assign hitLcr = hitIdx(wordIdx, `UMS_IDX_LCR);
    assign hitMcr = hitIdx(wordIdx, `UMS_IDX_MCR);
    assign hitLsr = hitIdx(wordIdx, `UMS_IDX_LSR);
    assign hitMsr = hitIdx(wordIdx, `UMS_IDX_MSR);
    assign hitScr = hitIdx(wordIdx, `UMS_IDX_SCR);
    assign hitSer = hitIdx(wordIdx, `UMS_IDX_SERCTL);

    // ----------------------------------------------------------------
    // bus phases
    // ----------------------------------------------------------------
    wire accessHold;
    wire rdLatch;
    wire wrDone;
    wire rdMsr;
    wire rdLsr;
    wire rdIir;

    assign mr         = masterResetIn;
    assign wordIdx    = paddr[7:2];
    assign accessHold = psel & penable & ~pready;
    // read side effects at the edge that captures the data, so an
    // event after that edge is kept for the next read
    assign rdLatch    = accessHold & ~pwrite & mapped;
    assign wrDone     = psel & penable & pready & pwrite & ~pslverr;
    assign rdMsr      = rdLatch & hitMsr;
    assign rdLsr      = rdLatch & hitLsr;
    assign rdIir      = rdLatch & hitIir;

    // ----------------------------------------------------------------
    // modem inputs
    // ----------------------------------------------------------------
    // bit order: clear to send, set ready, ring, carrier
    ums_change_det #(
        .N         (4),
        .RISE_MASK (4'h4)
    ) u_change (
        .clock       (clock),
        .rst_b       (rst_b),
        .masterReset (mr),
        .pinsIn      ({carrierDetect_b, ringIndicate_b,
                       setReady_b, clearSend_b}),
        .clearFlags  (rdMsr),
        .activeOut   (msrActive),
        .deltaOut    (msrDelta)
    );

    // ring sensing has no gate from terminal ready
    assign msrValue = {msrActive, msrDelta};

    ums_irq_ctrl u_irq (
        .interrupt_enable_reg      (ier_r),
        .line_status_reg      (lsr_r),
        .msrDelta (msrDelta),
        .threPend (threPend_r),
        .irqAny   (irqAny),
        .iid      (iid)
    );

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    always @* begin
        rdMux  = 32'h00000000;
        mapped = 1'b1;
        if (hitIer) begin
            rdMux[7:0] = ier_r;
        end else if (hitIir) begin
            rdMux[7:0] = iid;
        end else if (hitLcr) begin
            rdMux[7:0] = lcr_r;
        end else if (hitMcr) begin
            rdMux[7:0] = mcr_r;
        end else if (hitLsr) begin
            rdMux[7:0] = lsr_r;
        end else if (hitMsr) begin
            rdMux[7:0] = msrValue;
        end else if (hitScr) begin
            rdMux[7:0] = scr_r;
        end else if (hitSer) begin
            rdMux[0] = serialEnable;
        end else begin
            mapped = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // apb answer: one wait state, data from a flop
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (accessHold) begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h00000000 : rdMux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ier_r        <= `UMS_IER_RST;
            lcr_r        <= 8'h00;
            mcr_r        <= `UMS_MCR_RST;
            scr_r        <= 8'h00;
            serialEnable <= 1'b0;
        end else if (mr) begin
            mcr_r        <= `UMS_MCR_RST;
            serialEnable <= 1'b0;
        end else if (wrDone) begin
            if (hitIer) begin
                ier_r <= {4'h0, pwdata[3:0]};
            end else if (hitLcr) begin
                lcr_r <= pwdata[7:0];
            end else if (hitMcr) begin
                mcr_r <= {3'b000, pwdata[4:0]};
            end else if (hitScr) begin
                scr_r <= pwdata[7:0];
            end else if (hitSer) begin
                // stays idle until software re-enables it
                serialEnable <= pwdata[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // line status: set wins over clear
    // ----------------------------------------------------------------
    always @* begin
        lsr_nxt = lsr_r;
        if (rdLsr) begin
            lsr_nxt[`UMS_LSR_ERR_HI:`UMS_LSR_ERR_LO] = 4'h0;
        end
        lsr_nxt[`UMS_LSR_ERR_HI:`UMS_LSR_ERR_LO] =
            lsr_nxt[`UMS_LSR_ERR_HI:`UMS_LSR_ERR_LO] | rxErrSet;
        if (rxDataTaken) begin
            lsr_nxt[`UMS_LSR_DR] = 1'b0;
        end
        if (rxDataSet) begin
            lsr_nxt[`UMS_LSR_DR] = 1'b1;
        end
        if (txHoldLoad) begin
            lsr_nxt[`UMS_LSR_TX_HOLDING_EMPTY_FLAG] = 1'b0;
            lsr_nxt[`UMS_LSR_TX_SHIFTER_EMPTY_FLAG] = 1'b0;
        end
        if (txHoldFreed) begin
            lsr_nxt[`UMS_LSR_TX_HOLDING_EMPTY_FLAG] = 1'b1;
        end
        if (txShiftIdle) begin
            lsr_nxt[`UMS_LSR_TX_SHIFTER_EMPTY_FLAG] = 1'b1;
        end
        lsr_nxt[7] = 1'b0;
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lsr_r <= `UMS_LSR_RST;
        end else if (mr) begin
            lsr_r <= `UMS_LSR_RST;
        end else begin
            lsr_r <= lsr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // holding-empty interrupt: serviced by identity read or a load
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            threPend_r <= 1'b0;
        end else if (mr) begin
            threPend_r <= 1'b0;
        end else if (txHoldFreed) begin
            threPend_r <= 1'b1;
        end else if (txHoldLoad) begin
            threPend_r <= 1'b0;
        end else if (rdIir && iid == `UMS_IID_TX_HOLDING_EMPTY_FLAG) begin
            threPend_r <= 1'b0;
        end else if (wrDone && ier_r[`UMS_IER_TX_HOLDING_EMPTY_FLAG] == 1'b0 &&
                     hitIer &&
                     pwdata[`UMS_IER_TX_HOLDING_EMPTY_FLAG] && lsr_r[`UMS_LSR_TX_HOLDING_EMPTY_FLAG]) begin
            // enabling while already empty raises it at once
            threPend_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // pin outputs, all from flops
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            terminalReady_b     <= 1'b1;
            requestSend_b       <= 1'b1;
            auxOutputFirst_b    <= 1'b1;
            auxOutputSecond_b   <= 1'b1;
            interruptRequestOut <= 1'b0;
            rxSerialOut         <= 1'b1;
        end else if (mr) begin
            terminalReady_b     <= 1'b1;
            requestSend_b       <= 1'b1;
            auxOutputFirst_b    <= 1'b1;
            auxOutputSecond_b   <= 1'b1;
            interruptRequestOut <= 1'b0;
            rxSerialOut         <= 1'b1;
        end else begin
            terminalReady_b     <= ~mcr_r[`UMS_MCR_TREADY];
            requestSend_b       <= ~mcr_r[`UMS_MCR_RTS];
            auxOutputFirst_b    <= ~mcr_r[`UMS_MCR_AUX1] |
                                   mcr_r[`UMS_MCR_LOOP];
            auxOutputSecond_b   <= ~mcr_r[`UMS_MCR_AUX2] |
                                   mcr_r[`UMS_MCR_LOOP];
            interruptRequestOut <= irqAny;
            // line high is mark; carrier input plays no part here
            if (mcr_r[`UMS_MCR_LOOP]) begin
                rxSerialOut <= txSerialIn;
            end else begin
                rxSerialOut <= serialLineIn;
            end
        end
    end

endmodule

//--- common/ums_regs.vh
// register indices, field positions and reset values of the modem block
`ifndef UMS_REGS_VH
`define UMS_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define UMS_IDX_IER      4'h1
`define UMS_IDX_IIR      4'h2
`define UMS_IDX_LCR      4'h3
`define UMS_IDX_MCR      4'h4
`define UMS_IDX_LSR      4'h5
`define UMS_IDX_MSR      4'h6
`define UMS_IDX_SCR      4'h7
`define UMS_IDX_SERCTL   4'h8

// ----------------------------------------------------------------
// interrupt enable bits
// ----------------------------------------------------------------
`define UMS_IER_RXDATA   0
`define UMS_IER_TX_HOLDING_EMPTY_FLAG     1
`define UMS_IER_RXLINE   2
`define UMS_IER_MODEM    3

// ----------------------------------------------------------------
// modem control bits
// ----------------------------------------------------------------
`define UMS_MCR_TREADY   0
`define UMS_MCR_RTS      1
`define UMS_MCR_AUX1     2
`define UMS_MCR_AUX2     3
`define UMS_MCR_LOOP     4

// ----------------------------------------------------------------
// line status bits
// ----------------------------------------------------------------
`define UMS_LSR_DR       0
`define UMS_LSR_ERR_LO   1
`define UMS_LSR_ERR_HI   4
`define UMS_LSR_TX_HOLDING_EMPTY_FLAG     5
`define UMS_LSR_TX_SHIFTER_EMPTY_FLAG     6

// ----------------------------------------------------------------
// reset values and interrupt identities
// ----------------------------------------------------------------
`define UMS_MCR_RST      8'h00
`define UMS_LSR_RST      8'h60
`define UMS_IER_RST      8'h00
`define UMS_IID_NONE     8'h01
`define UMS_IID_LINE     8'h06
`define UMS_IID_RXDATA   8'h04
`define UMS_IID_TX_HOLDING_EMPTY_FLAG     8'h02
`define UMS_IID_MODEM    8'h00

`endif

//--- logic/ums_change_det.v
// modem input sampling and sticky change flags
`timescale 1ns/10ps
module ums_change_det #(
    parameter N         = 4,
    parameter RISE_MASK = 4'h4
) (
    input  wire         clock,
    input  wire         rst_b,
    input  wire         masterReset,
    input  wire [N-1:0] pinsIn,
    input  wire         clearFlags,
    output wire [N-1:0] activeOut,
    output reg  [N-1:0] deltaOut
);

    reg [N-1:0] sample_r;
    reg [N-1:0] prev_r;

    // pins are active low; status shows the active state
    assign activeOut = ~sample_r;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sample_r <= {N{1'b1}};
            prev_r   <= {N{1'b1}};
        end else begin
            sample_r <= pinsIn;
            prev_r   <= sample_r;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_flag
            wire evt;
            // masked inputs report only a low to high pin change
            assign evt = RISE_MASK[i] ? (~prev_r[i] & sample_r[i])
                                      : (prev_r[i] ^ sample_r[i]);
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    deltaOut[i] <= 1'b0;
                end else if (masterReset) begin
                    deltaOut[i] <= 1'b0;
                end else if (evt) begin
                    deltaOut[i] <= 1'b1;
                end else if (clearFlags) begin
                    deltaOut[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

//--- logic/ums_irq_ctrl.v
// interrupt source priority and identity
`timescale 1ns/10ps
`include "ums_regs.vh"
module ums_irq_ctrl (
    input  wire [7:0] interrupt_enable_reg,
    input  wire [7:0] line_status_reg,
    input  wire [3:0] msrDelta,
    input  wire       threPend,
    output reg        irqAny,
    output reg  [7:0] iid
);

    wire lineSrc;
    wire dataSrc;
    wire threSrc;
    wire modemSrc;

    assign lineSrc  = interrupt_enable_reg[`UMS_IER_RXLINE] &
                      (|line_status_reg[`UMS_LSR_ERR_HI:`UMS_LSR_ERR_LO]);
    assign dataSrc  = interrupt_enable_reg[`UMS_IER_RXDATA] & line_status_reg[`UMS_LSR_DR];
    assign threSrc  = interrupt_enable_reg[`UMS_IER_TX_HOLDING_EMPTY_FLAG] & threPend;
    assign modemSrc = interrupt_enable_reg[`UMS_IER_MODEM] & (|msrDelta);

    always @* begin
        irqAny = lineSrc | dataSrc | threSrc | modemSrc;
        if (lineSrc) begin
            iid = `UMS_IID_LINE;
        end else if (dataSrc) begin
            iid = `UMS_IID_RXDATA;
        end else if (threSrc) begin
            iid = `UMS_IID_TX_HOLDING_EMPTY_FLAG;
        end else if (modemSrc) begin
            iid = `UMS_IID_MODEM;
        end else begin
            iid = `UMS_IID_NONE;
        end
    end

endmodule

//--- verif/ums_top_asserts.sv
// concurrent checks on the modem block ports
`timescale 1ns/10ps
module ums_top_asserts (
    input wire        clock,
    input wire        rst_b,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        masterResetIn,
    input wire        ringIndicate_b,
    input wire        carrierDetect_b,
    input wire        terminalReady_b,
    input wire        requestSend_b,
    input wire        auxOutputFirst_b,
    input wire        auxOutputSecond_b,
    input wire        serialEnable,
    input wire        interruptRequestOut
);
    // ----------------------------------------
    // shadow of control writes
    // ----------------------------------------
    wire       wrEdge = psel && penable && pready && pwrite && !masterResetIn;
    reg  [7:0] mcrShadow_r;
    reg        ierModem_r;
    reg  [1:0] age_r;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mcrShadow_r <= 8'h00;
            ierModem_r  <= 1'b0;
            age_r       <= 2'h0;
        end else begin
            if (age_r != 2'h3)
                age_r <= age_r + 2'h1;
            // held writes are dropped, so master reset wins
            if (masterResetIn)
                mcrShadow_r <= 8'h00;
            else if (wrEdge && paddr[7:2] == 6'h04)
                mcrShadow_r <= pwdata[7:0];
            if (wrEdge && paddr[7:2] == 6'h01)
                ierModem_r <= pwdata[3];
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_mrHeld;
        masterResetIn ##1 masterResetIn;
    endsequence
    sequence s_msrRead;
        psel && penable && pready && !pwrite && paddr[7:2] == 6'h06;
    endsequence
    property p_mrOuts;
        s_mrHeld |=> terminalReady_b && requestSend_b && auxOutputFirst_b
            && auxOutputSecond_b && !interruptRequestOut;
    endproperty
    a_mrOuts: assert property (p_mrOuts)
        else $error("outputs active after master reset");
    property p_mrIdle;
        s_mrHeld |=> !serialEnable;
    endproperty
    a_mrIdle: assert property (p_mrIdle)
        else $error("serial still enabled in master reset");
    property p_aux1;
        auxOutputFirst_b == ($past(masterResetIn) || $past(mcrShadow_r[4])
            || !$past(mcrShadow_r[2]));
    endproperty
    a_aux1: assert property (p_aux1)
        else $error("first aux output wrong");
    property p_aux2;
        auxOutputSecond_b == ($past(masterResetIn) || $past(mcrShadow_r[4])
            || !$past(mcrShadow_r[3]));
    endproperty
    a_aux2: assert property (p_aux2)
        else $error("second aux output wrong");
    property p_tready;
        terminalReady_b == ($past(masterResetIn) || !$past(mcrShadow_r[0]));
    endproperty
    a_tready: assert property (p_tready)
        else $error("terminal ready wrong");
    property p_rts;
        requestSend_b == ($past(masterResetIn) || !$past(mcrShadow_r[1]));
    endproperty
    a_rts: assert property (p_rts)
        else $error("request to send wrong");
    property p_ringBit;
        (age_r == 2'h3 && $stable(ringIndicate_b))[*6] ##0 s_msrRead
            |-> prdata[6] == !ringIndicate_b;
    endproperty
    a_ringBit: assert property (p_ringBit)
        else $error("ring status bit wrong");
    property p_dcdBit;
        (age_r == 2'h3 && $stable(carrierDetect_b))[*6] ##0 s_msrRead
            |-> prdata[7] == !carrierDetect_b;
    endproperty
    a_dcdBit: assert property (p_dcdBit)
        else $error("carrier status bit wrong");
    property p_ringIrq;
        age_r == 2'h3 && ierModem_r && $rose(ringIndicate_b) && !masterResetIn
            |-> ##[1:5] interruptRequestOut;
    endproperty
    a_ringIrq: assert property (p_ringIrq)
        else $error("no interrupt on ring release");
    property p_dcdIrq;
        age_r == 2'h3 && ierModem_r && $changed(carrierDetect_b)
            && !masterResetIn |-> ##[1:5] interruptRequestOut;
    endproperty
    a_dcdIrq: assert property (p_dcdIrq)
        else $error("no interrupt on carrier change");
endmodule

//--- verif/ums_modem_model.sv
// modem-side partner driving the active-low status pins and line
`timescale 1ns/10ps
module ums_modem_model (
    input  wire       clock,
    input  wire [3:0] activeReq,
    input  wire       lineReq,
    output logic      clearSend_b,
    output logic      setReady_b,
    output logic      ringIndicate_b,
    output logic      carrierDetect_b,
    output logic      serialLineIn
);
    initial begin
        {clearSend_b, setReady_b, ringIndicate_b, carrierDetect_b} = 4'hF;
        serialLineIn = 1'b1;
    end
    // pins move just after an edge, as a real modem would not wait on us
    always @(posedge clock) begin
        clearSend_b     <= !activeReq[0];
        setReady_b      <= !activeReq[1];
        ringIndicate_b  <= !activeReq[2];
        carrierDetect_b <= !activeReq[3];
        serialLineIn    <= lineReq;
    end
endmodule

//--- verif/tb.sv
// self-checking testbench for the modem signal block
`timescale 1ns/10ps
`include "ums_regs.vh"
module tb;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        masterResetIn = 1'b0;
    logic        txSerialIn = 1'b1;
    logic        rxDataSet = 1'b0;
    logic        txHoldFreed = 1'b0;
    logic [3:0]  activeReq = 4'h0;
    logic        lineReq = 1'b1;
    logic [31:0] rdData;
    logic        rdErr;
    logic [3:0]  rxErrSet = 4'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, clearSend_b, setReady_b, ringIndicate_b;
    wire         carrierDetect_b, terminalReady_b, requestSend_b, serialLineIn;
    wire         auxOutputFirst_b, auxOutputSecond_b, rxSerialOut;
    wire         serialEnable, interruptRequestOut;
    int          failures = 0;
    int          samplesChecked = 0;
    // data-taken and transmit load inputs stay quiet
    ums_top ums_top_inst (.*, .rxDataTaken(1'b0),
        .txHoldLoad(1'b0), .txShiftIdle(1'b0));
    ums_modem_model ums_modem_model_inst (.*);
    initial forever #10 clock = ~clock;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, got);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input string nm);
        apb(1'b0, idx, 32'h0);
        chk(nm, exp, rdData);
    endtask
    task automatic pins(input logic [3:0] exp);
        chk("modem outs", exp, {auxOutputSecond_b, auxOutputFirst_b,
            requestSend_b, terminalReady_b});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        pins(4'hF);
        rd(`UMS_IDX_MCR, 32'h00, "mcr");
        apb(1'b1, `UMS_IDX_LSR, 32'h00);
        rd(`UMS_IDX_LSR, 32'h60, "lsr");
        rd(4'hF, 32'h00, "unmapped");
        chk("slverr", 1'b1, rdErr);
    endtask
    task automatic t_mcr;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `UMS_IDX_MCR, 32'h1 << i);
            cyc(2);
            pins(~(4'h1 << i));
        end
        apb(1'b1, `UMS_IDX_MCR, 32'h1C);
        txSerialIn <= 1'b0;
        cyc(3);
        pins(4'hF);
        chk("loop rx", 1'b0, rxSerialOut);
        txSerialIn <= 1'b1;
        lineReq <= 1'b0;
        cyc(3);
        chk("loop rx", 1'b1, rxSerialOut);
        apb(1'b1, `UMS_IDX_MCR, 32'h0C);
        cyc(3);
        pins(4'h3);
        chk("space rx", 1'b0, rxSerialOut);
        lineReq <= 1'b1;
        activeReq <= 4'h8;
        cyc(4);
        chk("mark rx", 1'b1, rxSerialOut);
        activeReq <= 4'h0;
        cyc(5);
        rd(`UMS_IDX_MSR, 32'h08, "msr");
    endtask
    task automatic t_modem;
        apb(1'b1, `UMS_IDX_IER, 32'h08);
        activeReq <= 4'hF;
        cyc(6);
        chk("irq", 1'b1, interruptRequestOut);
        rd(`UMS_IDX_MSR, 32'hFB, "msr all on");
        cyc(2);
        chk("irq", 1'b0, interruptRequestOut);
        rd(`UMS_IDX_MSR, 32'hF0, "msr reread");
        activeReq <= 4'hB;
        cyc(6);
        chk("irq", 1'b1, interruptRequestOut);
        rd(`UMS_IDX_MSR, 32'hB4, "msr ring off");
        activeReq <= 4'h0;
        cyc(6);
        rd(`UMS_IDX_MSR, 32'h0B, "msr all off");
    endtask
    task automatic t_irq;
        apb(1'b1, `UMS_IDX_IER, 32'h01);
        rxDataSet <= 1'b1;
        @(posedge clock) rxDataSet <= 1'b0;
        cyc(3);
        chk("irq", 1'b1, interruptRequestOut);
        rd(`UMS_IDX_IIR, 32'h04, "iir data");
        apb(1'b1, `UMS_IDX_IER, 32'h00);
        cyc(2);
        chk("irq", 1'b0, interruptRequestOut);
        apb(1'b1, `UMS_IDX_IER, 32'h02);
        cyc(2);
        chk("irq", 1'b1, interruptRequestOut);
        rd(`UMS_IDX_IIR, 32'h02, "iir tx_holding_empty_flag");
        cyc(2);
        chk("irq", 1'b0, interruptRequestOut);
        txHoldFreed <= 1'b1;
        @(posedge clock) txHoldFreed <= 1'b0;
        cyc(3);
        chk("irq", 1'b1, interruptRequestOut);
    endtask
    task automatic t_master;
        apb(1'b1, `UMS_IDX_MCR, 32'h0F);
        apb(1'b1, `UMS_IDX_SERCTL, 32'h01);
        activeReq <= 4'h8;
        cyc(6);
        chk("enable", 1'b1, serialEnable);
        rxErrSet <= 4'h2;
        @(posedge clock) rxErrSet <= 4'h0;
        masterResetIn <= 1'b1;
        cyc(4);
        masterResetIn <= 1'b0;
        pins(4'hF);
        chk("irq", 1'b0, interruptRequestOut);
        chk("enable", 1'b0, serialEnable);
        rd(`UMS_IDX_MCR, 32'h00, "mcr");
        rd(`UMS_IDX_LSR, 32'h60, "lsr");
        rd(`UMS_IDX_MSR, 32'h80, "msr");
        activeReq <= 4'h0;
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        cyc(5);
        rst_b <= 1'b1;
        t_reset();
        t_mcr();
        t_modem();
        t_irq();
        t_master();
        cyc(4);
        close_out();
    end
    // whole run is about two hundred cycles; this is generous
    initial begin
        #400000;
        failures++;
        close_out();
    end
endmodule
bind ums_top ums_top_asserts ums_top_asserts_inst (.*);
